// >>> logic/hms_params.svh
// Register map, field positions, reset values and method codes of the homing sequencer.
`ifndef HMS_PARAMS_SVH
`define HMS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define HMS_OFS_CTRL 8'h00
`define HMS_OFS_METHOD 8'h04
`define HMS_OFS_FAST_VEL 8'h08
`define HMS_OFS_SLOW_VEL 8'h0c
`define HMS_OFS_HOME_OFS 8'h10
`define HMS_OFS_RET_DIST 8'h14
`define HMS_OFS_STATUS 8'h18
`define HMS_OFS_HOME_POS 8'h1c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define HMS_CTRL_START 0
`define HMS_CTRL_ABORT 1
`define HMS_CTRL_OFS_ZERO 2
`define HMS_STAT_BUSY 0
`define HMS_STAT_DONE 1
`define HMS_STAT_ERR 2
`define HMS_STAT_STATE_LSB 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define HMS_RST_METHOD 8'h00
`define HMS_RST_FAST_VEL 32'h0001_0000
`define HMS_RST_SLOW_VEL 32'h0000_3334
`define HMS_RST_HOME_OFS 32'h0000_0000
`define HMS_RST_RET_DIST 32'h0000_0000

// ----------------------------------------------------------------------
// Method codes (two's complement, 8 bits)
// ----------------------------------------------------------------------
`define HMS_M_SW_R_RIDX 8'h0b
`define HMS_M_SW_R_LIDX 8'h0c
`define HMS_M_SW_L_RIDX 8'h0d
`define HMS_M_SW_L_LIDX 8'h0e
`define HMS_M_IDX_NEG 8'h21
`define HMS_M_IDX_POS 8'h22
`define HMS_M_CUR_POS 8'h25
`define HMS_M_HS_NEG_IDX 8'hff
`define HMS_M_HS_POS_IDX 8'hfe
`define HMS_M_ABS_ENC 8'hfd
`define HMS_M_HS_POS_RET 8'hfc
`define HMS_M_HS_NEG_RET 8'hfb

`endif

// >>> logic/hms_pkg.sv
// Types shared by the homing sequencer modules.
package hms_pkg;

  typedef enum logic [2:0] {
    HMS_FK_NONE = 3'h0,
    HMS_FK_SW_SET = 3'h1,
    HMS_FK_SW_CLEAR = 3'h2,
    HMS_FK_SW_FALL = 3'h3,
    HMS_FK_HSTOP = 3'h4
  } hms_fast_kind_e;

  typedef enum logic [1:0] {
    HMS_SK_NONE = 2'h0,
    HMS_SK_INDEX = 2'h1,
    HMS_SK_RETURN = 2'h2
  } hms_slow_kind_e;

  typedef struct packed {
    logic valid;
    logic needs_abs;
    logic no_motion;
    logic force_zero;
    hms_fast_kind_e fast_kind;
    logic fast_pos;
    hms_slow_kind_e slow_kind;
    logic slow_pos;
  } hms_plan_s;

  typedef enum logic [4:0] {
    HMS_ST_IDLE = 5'b00001,
    HMS_ST_FAST = 5'b00010,
    HMS_ST_TURN = 5'b00100,
    HMS_ST_SLOW = 5'b01000,
    HMS_ST_FIN = 5'b10000
  } hms_state_e;

endpackage

// >>> logic/hms_dec_if.sv
// Carrier between the sequencer core and its method decoder.
`timescale 1ns/1ps
interface hms_dec_if;
  import hms_pkg::*;
  logic [7:0] method;
  logic in_sw;
  hms_plan_s plan;
  modport dec (input method, input in_sw, output plan);
  modport core (output method, output in_sw, input plan);
endinterface

// >>> logic/hms_method_dec.sv
// Method decoder: turns a method code into a phase plan.
`timescale 1ns/1ps
`include "hms_params.svh"
module hms_method_dec
  import hms_pkg::*;
(
  // Decoder carrier
  hms_dec_if.dec d
);

  function automatic hms_plan_s plan_of(input logic [7:0] m, input logic sw);
    hms_plan_s p;
    p = '{valid: 1'b1, needs_abs: 1'b0, no_motion: 1'b0, force_zero: 1'b0,
          fast_kind: HMS_FK_NONE, fast_pos: 1'b0, slow_kind: HMS_SK_INDEX,
          slow_pos: 1'b0};
    case (m)
      `HMS_M_SW_R_RIDX: begin
        p.fast_kind = sw ? HMS_FK_SW_CLEAR : HMS_FK_SW_SET;
        p.fast_pos = sw;
        p.slow_pos = 1'b1;
      end
      `HMS_M_SW_R_LIDX: begin
        p.fast_kind = HMS_FK_SW_SET;
      end
      `HMS_M_SW_L_RIDX: begin
        p.fast_kind = HMS_FK_SW_FALL;
        p.slow_pos = 1'b1;
      end
      `HMS_M_SW_L_LIDX: begin
        p.fast_kind = HMS_FK_SW_FALL;
      end
      `HMS_M_IDX_NEG: begin
        p.slow_pos = 1'b0;
      end
      `HMS_M_IDX_POS: begin
        p.slow_pos = 1'b1;
      end
      `HMS_M_CUR_POS: begin
        p.no_motion = 1'b1;
        p.slow_kind = HMS_SK_NONE;
      end
      `HMS_M_HS_NEG_IDX: begin
        p.fast_kind = HMS_FK_HSTOP;
        p.slow_pos = 1'b1;
      end
      `HMS_M_HS_POS_IDX: begin
        p.fast_kind = HMS_FK_HSTOP;
        p.fast_pos = 1'b1;
      end
      `HMS_M_ABS_ENC: begin
        p.no_motion = 1'b1;
        p.needs_abs = 1'b1;
        p.slow_kind = HMS_SK_NONE;
      end
      `HMS_M_HS_POS_RET: begin
        p.fast_kind = HMS_FK_HSTOP;
        p.fast_pos = 1'b1;
        p.slow_kind = HMS_SK_RETURN;
        p.force_zero = 1'b1;
      end
      `HMS_M_HS_NEG_RET: begin
        p.fast_kind = HMS_FK_HSTOP;
        p.slow_kind = HMS_SK_RETURN;
        p.slow_pos = 1'b1;
        p.force_zero = 1'b1;
      end
      default: begin
        p.valid = 1'b0;
        p.slow_kind = HMS_SK_NONE;
      end
    endcase
    return p;
  endfunction

  assign d.plan = plan_of(d.method, d.in_sw);

endmodule

// >>> logic/hms_top.sv
// Homing sequencer: AHB-Lite register slave and phase state machine.
`timescale 1ns/1ps
`include "hms_params.svh"
module hms_top
  import hms_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Axis sensors
  input wire logic [31:0] act_pos,
  input wire logic home_sw,
  input wire logic index_pulse,
  input wire logic hard_stop,
  input wire logic abs_enc_fitted,
  // Motion command
  output logic mot_run,
  output logic mot_pos_dir,
  output logic [31:0] mot_speed,
  output logic pos_set,
  output logic [31:0] pos_set_val,
  output logic homing_busy
);

  // ----------------------------------------------------------------------
  // AHB address phase capture
  // ----------------------------------------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  wire addr_ok = hsel && hready && htrans[1];
  wire [7:0] a_ofs = {haddr[7:2], 2'b00};
  wire in_map = (haddr[31:8] == 24'h00_0000) && (haddr[7:5] == 3'h0);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] method_q;
  logic [31:0] fast_vel_q;
  logic [31:0] slow_vel_q;
  logic [31:0] home_ofs_q;
  logic [31:0] ret_dist_q;
  logic ofs_zero_q;
  logic done_q;
  logic err_q;
  logic [31:0] home_pos_q;

  function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] o);
    return pend && (a == o);
  endfunction

  wire wr_ctrl = wr_hit(wr_pend_q, wr_addr_q, `HMS_OFS_CTRL);
  wire wr_status = wr_hit(wr_pend_q, wr_addr_q, `HMS_OFS_STATUS);
  wire start_req = wr_ctrl && hwdata[`HMS_CTRL_START];
  wire abort_req = wr_ctrl && hwdata[`HMS_CTRL_ABORT];

  // ----------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------
  hms_state_e state_q;
  hms_state_e state_d;
  hms_plan_s plan_q;
  logic sw_q;
  logic evt_q;
  logic [31:0] ret_start_q;
  logic run_q;
  logic dir_q;
  logic [31:0] speed_q;
  logic pos_set_q;
  logic [31:0] pos_val_q;
  logic done_set;
  logic err_set;

  hms_dec_if dec_bus ();
  assign dec_bus.method = method_q;
  assign dec_bus.in_sw = home_sw;

  hms_method_dec u_dec (
    .d(dec_bus)
  );

  hms_plan_s new_plan;
  assign new_plan = dec_bus.plan;

  // A method that needs an absolute encoder is refused when none is fitted.
  // encoder check
  wire plan_ok = new_plan.valid && (!new_plan.needs_abs || abs_enc_fitted);

  // Qualifying events of the fast phase; switch falling edge uses last sample.
  wire sw_fall = sw_q && !home_sw;
  logic fast_evt;
  always_comb begin
    case (plan_q.fast_kind)
      HMS_FK_SW_SET: fast_evt = home_sw;
      HMS_FK_SW_CLEAR: fast_evt = !home_sw;
      HMS_FK_SW_FALL: fast_evt = sw_fall;
      HMS_FK_HSTOP: fast_evt = hard_stop;
      default: fast_evt = 1'b1;
    endcase
  end

  // Distance travelled since the hard stop, as a magnitude.
  wire [31:0] trav = act_pos - ret_start_q;
  wire [31:0] trav_abs = trav[31] ? (32'h0 - trav) : trav;
  wire ret_reached = trav_abs >= ret_dist_q;
  logic slow_evt;
  always_comb begin
    case (plan_q.slow_kind)
      HMS_SK_INDEX: slow_evt = index_pulse;
      HMS_SK_RETURN: slow_evt = ret_reached;
      default: slow_evt = 1'b1;
    endcase
  end

  wire [31:0] home_val = (plan_q.force_zero || ofs_zero_q) ? 32'h0 : home_ofs_q;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    done_set = 1'b0;
    err_set = 1'b0;
    case (state_q)
      HMS_ST_IDLE: begin
        if (start_req) begin
          if (!plan_ok) begin
            err_set = 1'b1;
          end else if (new_plan.no_motion) begin
            done_set = 1'b1;
          end else if (new_plan.fast_kind == HMS_FK_NONE) begin
            state_d = HMS_ST_SLOW;
          end else begin
            state_d = HMS_ST_FAST;
          end
        end
      end
      HMS_ST_FAST: begin
        if (abort_req) begin
          state_d = HMS_ST_IDLE;
          err_set = 1'b1;
        end else if (fast_evt) begin
          state_d = HMS_ST_TURN;
        end
      end
      HMS_ST_TURN: begin
        if (abort_req) begin
          state_d = HMS_ST_IDLE;
          err_set = 1'b1;
        end else if (evt_q) begin
          state_d = HMS_ST_SLOW;
        end
      end
      HMS_ST_SLOW: begin
        if (abort_req) begin
          state_d = HMS_ST_IDLE;
          err_set = 1'b1;
        end else if (slow_evt) begin
          state_d = HMS_ST_FIN;
        end
      end
      HMS_ST_FIN: begin
        state_d = HMS_ST_IDLE;
        done_set = 1'b1;
      end
      default: state_d = HMS_ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= HMS_ST_IDLE;
      sw_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sw_q <= home_sw;
    end
  end

  // The plan is frozen at start so a register write mid-run cannot change it.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      plan_q <= '0;
    end else if (state_q == HMS_ST_IDLE && start_req) begin
      plan_q <= new_plan;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      evt_q <= 1'b0;
      ret_start_q <= 32'h0;
    end else if (state_q == HMS_ST_FAST && fast_evt) begin
      evt_q <= 1'b1;
      ret_start_q <= act_pos;
    end else if (state_q == HMS_ST_IDLE) begin
      evt_q <= 1'b0;
    end
  end

  // Motion command: fast phase uses faster speed, slow phase the slower one.
  // two velocities used
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      run_q <= 1'b0;
      dir_q <= 1'b0;
      speed_q <= 32'h0;
    end else begin
      run_q <= (state_d == HMS_ST_FAST) || (state_d == HMS_ST_SLOW);
      if (state_d == HMS_ST_FAST) begin
        dir_q <= (state_q == HMS_ST_IDLE) ? new_plan.fast_pos : plan_q.fast_pos;
        speed_q <= fast_vel_q;
      end else if (state_d == HMS_ST_SLOW) begin
        dir_q <= (state_q == HMS_ST_IDLE) ? new_plan.slow_pos : plan_q.slow_pos;
        speed_q <= slow_vel_q;
      end else begin
        speed_q <= 32'h0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pos_set_q <= 1'b0;
      pos_val_q <= 32'h0;
      home_pos_q <= 32'h0;
    end else begin
      pos_set_q <= (state_q == HMS_ST_FIN);
      if (state_q == HMS_ST_FIN) begin
        pos_val_q <= home_val;
        home_pos_q <= home_val;
      end else if (state_q == HMS_ST_IDLE && start_req && plan_ok && new_plan.no_motion) begin
        home_pos_q <= act_pos;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite && in_map;
      wr_addr_q <= a_ofs;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      method_q <= `HMS_RST_METHOD;
      fast_vel_q <= `HMS_RST_FAST_VEL;
      slow_vel_q <= `HMS_RST_SLOW_VEL;
      home_ofs_q <= `HMS_RST_HOME_OFS;
      ret_dist_q <= `HMS_RST_RET_DIST;
      ofs_zero_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ofs_zero_q <= hwdata[`HMS_CTRL_OFS_ZERO];
      end
      if (wr_hit(wr_pend_q, wr_addr_q, `HMS_OFS_METHOD)) begin
        method_q <= hwdata[7:0];
      end
      if (wr_hit(wr_pend_q, wr_addr_q, `HMS_OFS_FAST_VEL)) begin
        fast_vel_q <= hwdata;
      end
      if (wr_hit(wr_pend_q, wr_addr_q, `HMS_OFS_SLOW_VEL)) begin
        slow_vel_q <= hwdata;
      end
      if (wr_hit(wr_pend_q, wr_addr_q, `HMS_OFS_HOME_OFS)) begin
        home_ofs_q <= hwdata;
      end
      if (wr_hit(wr_pend_q, wr_addr_q, `HMS_OFS_RET_DIST)) begin
        ret_dist_q <= hwdata;
      end
    end
  end

  // Sticky flags: a new event in the clearing cycle wins over the clear.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      done_q <= done_set || (done_q && !(wr_status && hwdata[`HMS_STAT_DONE]));
      err_q <= err_set || (err_q && !(wr_status && hwdata[`HMS_STAT_ERR]));
    end
  end

  // ----------------------------------------------------------------------
  // Read data, captured in the address phase so no wait state is needed
  // ----------------------------------------------------------------------
  wire [31:0] status_word = {19'h0, state_q, 5'h0, err_q, done_q, (state_q != HMS_ST_IDLE)};
  logic [31:0] rd_mux;
  always_comb begin
    case (a_ofs)
      `HMS_OFS_CTRL: rd_mux = {29'h0, ofs_zero_q, 2'b00};
      `HMS_OFS_METHOD: rd_mux = {24'h0, method_q};
      `HMS_OFS_FAST_VEL: rd_mux = fast_vel_q;
      `HMS_OFS_SLOW_VEL: rd_mux = slow_vel_q;
      `HMS_OFS_HOME_OFS: rd_mux = home_ofs_q;
      `HMS_OFS_RET_DIST: rd_mux = ret_dist_q;
      `HMS_OFS_STATUS: rd_mux = status_word;
      `HMS_OFS_HOME_POS: rd_mux = home_pos_q;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      rdata_q <= in_map ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mot_run = run_q;
  assign mot_pos_dir = dir_q;
  assign mot_speed = speed_q;
  assign pos_set = pos_set_q;
  assign pos_set_val = pos_val_q;
  assign homing_busy = (state_q != HMS_ST_IDLE);

endmodule

// >>> bench/hms_top_checker.sv
// Concurrent checks on the homing sequencer's bus response and motion ports.
`timescale 1ns/1ps
module hms_top_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Bus response
  input wire logic hreadyout,
  input wire logic hresp,
  // Motion command
  input wire logic mot_run,
  input wire logic mot_pos_dir,
  input wire logic [31:0] mot_speed,
  input wire logic pos_set,
  input wire logic [31:0] pos_set_val,
  input wire logic homing_busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // A busy cycle without motion is either the turn or the final stop.
  sequence pause_s;
    homing_busy && !mot_run;
  endsequence
  sequence fin_s;
    pause_s ##1 !homing_busy;
  endsequence

  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  AST_IDLE_STILL: assert property (!homing_busy |-> !mot_run)
    else $error("motion commanded while idle");
  AST_STOP_NO_SPEED: assert property (!mot_run |-> mot_speed == 32'h0)
    else $error("speed left on while stopped");
  AST_DIR_HELD: assert property (mot_run && $past(mot_run) |-> $stable(mot_pos_dir))
    else $error("direction reversed while moving");
  AST_PAUSE_ONE: assert property (pause_s |=> !(homing_busy && !mot_run))
    else $error("stop inside a run lasted more than one cycle");
  AST_FIN_SETS: assert property (fin_s |-> pos_set)
    else $error("run ended without defining the home position");
  AST_SET_AT_END: assert property (pos_set |-> !homing_busy && $past(homing_busy))
    else $error("home defined outside the end of a run");
  AST_SET_PULSE: assert property (pos_set |=> !pos_set)
    else $error("home define pulse longer than one cycle");
  AST_VAL_HELD: assert property ($changed(pos_set_val) |-> pos_set)
    else $error("home value changed without define pulse");
  AST_START_MOVES: assert property ($rose(homing_busy) |-> mot_run)
    else $error("run started without motion");
endmodule

bind hms_top hms_top_checker chk_u (
  .core_clk(core_clk),
  .resetn(resetn),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .mot_run(mot_run),
  .mot_pos_dir(mot_pos_dir),
  .mot_speed(mot_speed),
  .pos_set(pos_set),
  .pos_set_val(pos_set_val),
  .homing_busy(homing_busy)
);

// >>> bench/hms_axis_model.sv
// Behavioural axis: motor, encoder, home switch, index mark and hard stops.
`timescale 1ns/1ps
module hms_axis_model #(
  parameter int SW_LO = 100,
  parameter int SW_HI = 200,
  parameter int STOP_LO = -300,
  parameter int STOP_HI = 300
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Bench placement
  input wire logic place,
  input wire logic [31:0] place_pos,
  // Motion command
  input wire logic mot_run,
  input wire logic mot_pos_dir,
  // Sensors
  output logic [31:0] act_pos,
  output logic home_sw,
  output logic index_pulse,
  output logic hard_stop
);
  logic signed [31:0] pos_q;

  // The axis cannot push further into a hard stop, so a missed stop stalls the run.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pos_q <= 32'sh0;
    end else if (place) begin
      pos_q <= place_pos;
    end else if (mot_run && mot_pos_dir && pos_q < STOP_HI) begin
      pos_q <= pos_q + 32'sh1;
    end else if (mot_run && !mot_pos_dir && pos_q > STOP_LO) begin
      pos_q <= pos_q - 32'sh1;
    end
  end

  assign act_pos = pos_q;
  assign home_sw = (pos_q >= SW_LO) && (pos_q <= SW_HI);
  assign index_pulse = (pos_q[4:0] == 5'h0);
  assign hard_stop = (pos_q <= STOP_LO) || (pos_q >= STOP_HI);
endmodule

// >>> bench/tb.sv
// Self-checking bench for the homing sequencer over its register bus.
`timescale 1ns/1ps
`include "hms_params.svh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error %s exp %0h got %0h", nm, exp, got); end end
module tb;
  localparam logic [31:0] FASTV = 32'h0000_0040;
  localparam logic [31:0] SLOWV = 32'h0000_0010;
  localparam logic [31:0] HOFS = 32'h0000_0055;
  logic core_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, abs_fit = 1'b0, place = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, place_pos = 32'h0, rd;
  logic hreadyout, hresp, mot_run, mot_pos_dir, pos_set, homing_busy, home_sw, idx, hstop;
  logic [31:0] hrdata, mot_speed, pos_set_val, act_pos, set_val;
  logic saw_f, f_dir, s_dir, got_set;
  logic [7:0] bad [6] = '{8'h00, 8'h0a, 8'h0f, 8'h24, 8'h80, 8'hfd};
  int num_errors = 0;
  int n_tests = 0;

  always #50 core_clk = ~core_clk;

  hms_top dut_u (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .act_pos(act_pos),
    .home_sw(home_sw), .index_pulse(idx), .hard_stop(hstop), .abs_enc_fitted(abs_fit),
    .mot_run(mot_run), .mot_pos_dir(mot_pos_dir), .mot_speed(mot_speed), .pos_set(pos_set),
    .pos_set_val(pos_set_val), .homing_busy(homing_busy));

  hms_axis_model axis_u (.core_clk(core_clk), .resetn(resetn), .place(place),
    .place_pos(place_pos), .mot_run(mot_run), .mot_pos_dir(mot_pos_dir), .act_pos(act_pos),
    .home_sw(home_sw), .index_pulse(idx), .hard_stop(hstop));

  // ----------------------------------------------------------------------
  // Monitor and bus tasks
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (mot_run === 1'b1 && mot_speed === FASTV) begin
      saw_f <= 1'b1;
      f_dir <= mot_pos_dir;
    end
    if (mot_run === 1'b1 && mot_speed === SLOWV) s_dir <= mot_pos_dir;
    if (pos_set === 1'b1) begin
      got_set <= 1'b1;
      set_val <= pos_set_val;
    end
  end

  task xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ofs};
    hwrite <= wr;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask

  task rchk(input string nm, input logic [7:0] ofs, input logic [31:0] msk, input logic [31:0] exp);
    xfer(1'b0, ofs, 32'h0);
    `CHK(nm, exp, rd & msk)
  endtask

  task start(input logic [7:0] code, input logic [31:0] at, input logic oz);
    place <= 1'b1;
    place_pos <= at;
    @(posedge core_clk);
    place <= 1'b0;
    xfer(1'b1, `HMS_OFS_METHOD, {24'h0, code});
    saw_f = 1'b0;
    got_set = 1'b0;
    f_dir = 1'bx;
    s_dir = 1'bx;
    xfer(1'b1, `HMS_OFS_CTRL, {29'h0, oz, 2'b01});
  endtask

  task run_m(input logic [7:0] code, input logic [31:0] at, input logic oz, input logic hasf,
    input logic fd, input logic sd, input logic [31:0] hv);
    int n;
    start(code, at, oz);
    n = 0;
    @(posedge core_clk);
    while (homing_busy !== 1'b0 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) num_errors++;
    @(posedge core_clk);
    `CHK("fast phase", hasf, saw_f)
    if (hasf) `CHK("fast dir", fd, f_dir)
    `CHK("slow dir", sd, s_dir)
    `CHK("home set", 1'b1, got_set)
    `CHK("home value", hv, set_val)
    rchk("done", `HMS_OFS_STATUS, 32'h7, 32'h2);
    xfer(1'b1, `HMS_OFS_STATUS, 32'h7);
  endtask

  task finish_test;
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rchk("method rst", `HMS_OFS_METHOD, 32'hff, 32'h0);
    rchk("fast rst", `HMS_OFS_FAST_VEL, 32'hffff_ffff, `HMS_RST_FAST_VEL);
    rchk("slow rst", `HMS_OFS_SLOW_VEL, 32'hffff_ffff, `HMS_RST_SLOW_VEL);
    rchk("status rst", `HMS_OFS_STATUS, 32'h7, 32'h0);
    xfer(1'b1, 8'h20, 32'h1234_5678);
    rchk("unmapped", 8'h20, 32'hffff_ffff, 32'h0);
    xfer(1'b1, `HMS_OFS_FAST_VEL, FASTV);
    xfer(1'b1, `HMS_OFS_SLOW_VEL, SLOWV);
    xfer(1'b1, `HMS_OFS_HOME_OFS, HOFS);
    xfer(1'b1, `HMS_OFS_RET_DIST, 32'h8);
    rchk("slow vel", `HMS_OFS_SLOW_VEL, 32'hffff_ffff, SLOWV);
    // Without an absolute encoder the last code of the list must be refused too.
    foreach (bad[i]) begin
      start(bad[i], 32'd50, 1'b0);
      @(posedge core_clk);
      `CHK("no motion", 1'b0, mot_run)
      rchk("refused", `HMS_OFS_STATUS, 32'h7, 32'h4);
      xfer(1'b1, `HMS_OFS_STATUS, 32'h4);
    end
    abs_fit <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      start(i == 0 ? `HMS_M_CUR_POS : `HMS_M_ABS_ENC, 32'h4d + i, 1'b0);
      repeat (3) @(posedge core_clk);
      `CHK("still", 1'b0, mot_run)
      `CHK("no pulse", 1'b0, got_set)
      rchk("home pos", `HMS_OFS_HOME_POS, 32'hffff_ffff, 32'h4d + i);
      rchk("taken", `HMS_OFS_STATUS, 32'h7, 32'h2);
      xfer(1'b1, `HMS_OFS_STATUS, 32'h7);
    end
    run_m(`HMS_M_SW_R_RIDX, 32'd260, 1'b0, 1'b1, 1'b0, 1'b1, HOFS);
    run_m(`HMS_M_SW_R_RIDX, 32'd150, 1'b1, 1'b1, 1'b1, 1'b1, 32'h0);
    run_m(`HMS_M_SW_R_LIDX, 32'd260, 1'b0, 1'b1, 1'b0, 1'b0, HOFS);
    run_m(`HMS_M_SW_R_LIDX, 32'd150, 1'b0, 1'b1, 1'b0, 1'b0, HOFS);
    run_m(`HMS_M_SW_L_RIDX, 32'd260, 1'b0, 1'b1, 1'b0, 1'b1, HOFS);
    run_m(`HMS_M_SW_L_LIDX, 32'd260, 1'b0, 1'b1, 1'b0, 1'b0, HOFS);
    run_m(`HMS_M_IDX_NEG, 32'd10, 1'b0, 1'b0, 1'b0, 1'b0, HOFS);
    run_m(`HMS_M_IDX_POS, 32'd10, 1'b1, 1'b0, 1'b0, 1'b1, 32'h0);
    run_m(`HMS_M_HS_NEG_IDX, 32'd0, 1'b0, 1'b1, 1'b0, 1'b1, HOFS);
    run_m(`HMS_M_HS_POS_IDX, 32'd0, 1'b0, 1'b1, 1'b1, 1'b0, HOFS);
    run_m(`HMS_M_HS_POS_RET, 32'd0, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0);
    run_m(`HMS_M_HS_NEG_RET, 32'd0, 1'b1, 1'b1, 1'b0, 1'b1, 32'h0);
    start(`HMS_M_HS_NEG_IDX, 32'd0, 1'b0);
    repeat (5) @(posedge core_clk);
    xfer(1'b1, `HMS_OFS_CTRL, 32'h2);
    @(posedge core_clk);
    `CHK("abort stop", 1'b0, mot_run)
    rchk("abort err", `HMS_OFS_STATUS, 32'h7, 32'h4);
    finish_test();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    finish_test();
  end
endmodule
